// ---- logic/xad_exec.sv ----
/*
 Execution unit for three instructions: port-direction load from the
 accumulator, XOR literal into the accumulator, XOR accumulator with file.

 Every instruction completes in the cycle it is presented: the result is
 visible in the accumulator, the zero flag, a direction register or the
 file write-back port right after the edge that takes it. Back-to-back
 instructions are allowed, and each one sees the accumulator value that
 the previous one left behind.

 Assumes the decoder supplies the file operand already read for the
 addressed location, and that the file write port takes fwr the next cycle.
 Assumes one clock, with every input synchronous to it, and an
 asynchronous active-low reset that is released synchronously upstream.
 A file XOR that writes back and a following instruction that reads the
 same location must be spaced by the caller; nothing here forwards it.
*/
`timescale 1ns/1ns

module xad_exec
   import xad_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Decoded instruction
   input wire logic instr_valid,
   input xad_instr_type instr,
   input wire logic [XAD_DATA_W-1:0] file_rdata,
   // Architectural state
   output logic [XAD_DATA_W-1:0] acc_q,
   output logic zero_flag_q,
   output logic [XAD_DATA_W-1:0] port_a_direction_reg,
   output logic [XAD_DATA_W-1:0] port_b_direction_reg,
   output logic [XAD_DATA_W-1:0] port_c_direction_reg,
   // File register write-back
   output xad_file_wr_type file_wr_q,
   // Invalid direction operand seen
   output logic bad_operand_q
);

   // Number of direction registers, one per port
   localparam int NUM_DIR = 3;

   // Operand code of each direction register, in port order
   localparam logic [XAD_SEL_W-1:0] DIR_CODE [NUM_DIR] = '{
      XAD_SEL_PORT_A,
      XAD_SEL_PORT_B,
      XAD_SEL_PORT_C
   };

   // Registered state and its next value
   xad_state_type st_q;
   xad_state_type st_d;

   // Direction load decode
   logic do_dir_load;
   logic [NUM_DIR-1:0] dir_hit;
   logic dir_operand_ok;

   // Direction registers as an array so one loop serves all ports
   logic [XAD_DATA_W-1:0] dir_cur [NUM_DIR];
   logic [XAD_DATA_W-1:0] dir_nxt [NUM_DIR];

   // Shared XOR datapath
   logic [XAD_DATA_W-1:0] xor_operand;
   logic [XAD_DATA_W-1:0] xor_res;
   logic xor_is_zero;
   logic xor_to_file;

   // Direction load strobe; gated by valid so idle cycles never load
   assign do_dir_load = instr_valid && (instr.op == XAD_OP_LOAD_DIR);

   // Present direction values, in the same order as DIR_CODE
   assign dir_cur[0] = st_q.dir_a;
   assign dir_cur[1] = st_q.dir_b;
   assign dir_cur[2] = st_q.dir_c;

   // Per-port select and load; exactly one port can match a legal code
   for (genvar gi = 0; gi < NUM_DIR; gi++) begin : g_dir
      // Port matches its own operand code only
      assign dir_hit[gi] = do_dir_load && (instr.dir_sel == DIR_CODE[gi]);
      // Whole accumulator copied, no partial write
      assign dir_nxt[gi] = dir_hit[gi] ? st_q.acc : dir_cur[gi];
   end

   // Codes outside 5..7 match no port and only raise the report pulse
   assign dir_operand_ok = |dir_hit;

   // Shared XOR path; one XOR serves both instructions to save area
   assign xor_operand = (instr.op == XAD_OP_XOR_LIT) ? instr.literal : file_rdata;
   assign xor_res = st_q.acc ^ xor_operand;

   // Zero detect on the XOR result, before it is steered anywhere
   assign xor_is_zero = (xor_res == {XAD_DATA_W{1'b0}});

   // Destination bit of the file XOR
   assign xor_to_file = (instr.dest == XAD_DEST_FILE);

   // Next state; write-back and report pulses last exactly one cycle
   always_comb begin
      st_d = st_q;
      // Pulses drop unless raised again this cycle
      st_d.fwr.we = 1'b0;
      // Direction registers; unselected ones keep their value
      st_d.dir_a = dir_nxt[0];
      st_d.dir_b = dir_nxt[1];
      st_d.dir_c = dir_nxt[2];
      // Illegal direction operand reported, nothing else changes
      st_d.bad_operand = do_dir_load && !dir_operand_ok;
      if (instr_valid) begin
         case (instr.op)
            XAD_OP_XOR_LIT: begin
               st_d.acc = xor_res;
               st_d.zero = xor_is_zero;
            end
            XAD_OP_XOR_FILE: begin
               // Zero follows the result wherever it goes
               st_d.zero = xor_is_zero;
               if (xor_to_file) begin
                  st_d.fwr.we = 1'b1;
                  st_d.fwr.addr = instr.file_addr;
                  st_d.fwr.data = xor_res;
               end else begin
                  st_d.acc = xor_res;
               end
            end
            default: begin
               // Direction load and no-op leave acc and flags alone
               st_d.zero = st_q.zero;
            end
         endcase
      end
   end

   // State register; reset branch loads constants only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= XAD_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops, no logic after the register
   assign acc_q = st_q.acc;
   assign zero_flag_q = st_q.zero;
   assign port_a_direction_reg = st_q.dir_a;
   assign port_b_direction_reg = st_q.dir_b;
   assign port_c_direction_reg = st_q.dir_c;
   assign file_wr_q = st_q.fwr;
   assign bad_operand_q = st_q.bad_operand;

endmodule

// ---- logic/xad_pkg.sv ----
/*
 Package for the XOR and port-direction load execution block.
 Holds operand codes, widths, reset values and the carrier structs.
 Assumes the CPU front end presents one decoded instruction per cycle.
*/
package xad_pkg;

   localparam int XAD_DATA_W = 8;
   localparam int XAD_ADDR_W = 7;
   localparam int XAD_SEL_W = 3;

   // Port-direction operand codes
   localparam logic [XAD_SEL_W-1:0] XAD_SEL_PORT_A = 3'h5;
   localparam logic [XAD_SEL_W-1:0] XAD_SEL_PORT_B = 3'h6;
   localparam logic [XAD_SEL_W-1:0] XAD_SEL_PORT_C = 3'h7;

   // Values after reset
   localparam logic [XAD_DATA_W-1:0] XAD_ACC_RST = 8'h00;
   localparam logic [XAD_DATA_W-1:0] XAD_DIR_RST = 8'hFF; // All pins input
   localparam logic XAD_ZERO_RST = 1'b0;

   // Result destination bit values
   localparam logic XAD_DEST_ACC = 1'b0;
   localparam logic XAD_DEST_FILE = 1'b1;

   // Instruction codes presented by the decoder
   typedef enum logic [1:0] {
      XAD_OP_NONE = 2'b00,
      XAD_OP_LOAD_DIR = 2'b01,
      XAD_OP_XOR_LIT = 2'b10,
      XAD_OP_XOR_FILE = 2'b11
   } xad_op_type;

   // One decoded instruction
   typedef struct packed {
      xad_op_type op;
      logic [XAD_DATA_W-1:0] literal;
      logic [XAD_ADDR_W-1:0] file_addr;
      logic dest;
      logic [XAD_SEL_W-1:0] dir_sel;
   } xad_instr_type;

   // File register write-back request
   typedef struct packed {
      logic we;
      logic [XAD_ADDR_W-1:0] addr;
      logic [XAD_DATA_W-1:0] data;
   } xad_file_wr_type;

   // Whole state of the execution block
   typedef struct packed {
      logic [XAD_DATA_W-1:0] acc;
      logic zero;
      logic [XAD_DATA_W-1:0] dir_a;
      logic [XAD_DATA_W-1:0] dir_b;
      logic [XAD_DATA_W-1:0] dir_c;
      xad_file_wr_type fwr;
      logic bad_operand;
   } xad_state_type;

   localparam xad_state_type XAD_STATE_RST = '{
      acc: XAD_ACC_RST,
      zero: XAD_ZERO_RST,
      dir_a: XAD_DIR_RST,
      dir_b: XAD_DIR_RST,
      dir_c: XAD_DIR_RST,
      fwr: '0,
      bad_operand: 1'b0
   };

endpackage

// ---- verification/xad_chk.sv ----
/* Port checker for xad_exec.
   Bound to every instance of it. */
`timescale 1ns/1ns
module xad_chk
   import xad_pkg::*;
(
   // Clock, reset and instruction
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input xad_instr_type instr,
   input wire logic [7:0] file_rdata,
   // Results
   input wire logic [7:0] acc_q,
   input wire logic zero_flag_q,
   input wire logic [7:0] port_a_direction_reg,
   input wire logic [7:0] port_b_direction_reg,
   input wire logic [7:0] port_c_direction_reg,
   input xad_file_wr_type file_wr_q,
   input wire logic bad_operand_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Results are tied to the instruction one edge back
   sequence dir_s; instr_valid && instr.op == XAD_OP_LOAD_DIR; endsequence
   sequence lit_s; instr_valid && instr.op == XAD_OP_XOR_LIT; endsequence
   sequence fil_s; instr_valid && instr.op == XAD_OP_XOR_FILE; endsequence
   dir_load_a:
   assert property (dir_s ##0 instr.dir_sel == XAD_SEL_PORT_C |=> port_c_direction_reg == $past(acc_q))
      else $error("direction load wrong");
   dir_flags_a:
   assert property (dir_s |=> $stable(zero_flag_q) && $stable(acc_q)) else $error("direction load moved state");
   lit_xor_a:
   assert property (lit_s |=> acc_q == $past(acc_q ^ instr.literal)) else $error("literal xor wrong");
   file_xor_a:
   assert property (fil_s ##0 !instr.dest |=> acc_q == $past(acc_q ^ file_rdata)) else $error("file xor wrong");
   file_back_a:
   assert property (fil_s ##0 instr.dest |=> $stable(acc_q) &&
      file_wr_q == {1'b1, $past(instr.file_addr), $past(acc_q ^ file_rdata)}) else $error("write-back wrong");
   lit_zero_a:
   assert property (lit_s |=> zero_flag_q == (acc_q == 8'h00)) else $error("zero flag wrong");
   dir_a_load_a:
   assert property (dir_s ##0 instr.dir_sel == XAD_SEL_PORT_A |=> port_a_direction_reg == $past(acc_q))
      else $error("port a direction load wrong");
   dir_b_load_a:
   assert property (dir_s ##0 instr.dir_sel == XAD_SEL_PORT_B |=> port_b_direction_reg == $past(acc_q))
      else $error("port b direction load wrong");
   bad_op_a:
   assert property (dir_s ##0 instr.dir_sel < XAD_SEL_PORT_A |=> bad_operand_q && $stable(port_a_direction_reg)
      && $stable(port_b_direction_reg) && $stable(port_c_direction_reg)) else $error("bad operand not refused");
   file_zero_a:
   assert property (fil_s |=> zero_flag_q == ($past(acc_q ^ file_rdata) == 8'h00)) else $error("file zero wrong");
endmodule

bind xad_exec xad_chk chk_u (.*);

// ---- verification/xor_and_dir_load_ops_tb.sv ----
/* Random bench for xad_exec against an integer model.
   Assumes the checker is compiled beside it. */
`timescale 1ns/1ns
module xor_and_dir_load_ops_tb
   import xad_pkg::*;
;
   logic mclk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, zero_flag_q, bad_operand_q, v;
   xad_instr_type instr = '0, t;
   logic [7:0] file_rdata = 8'h00, fd, acc_q, dir_a, dir_b, dir_c;
   xad_file_wr_type file_wr_q;
   logic [31:0] seed = 32'h0001116A;
   int miscompares = 0, cmp_count = 0, acc = 0, z = 0, bad = 0, wr = 0, res;
   int d[3] = '{3{255}};
   always #5 mclk = ~mclk;
   xad_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
      .acc_q(acc_q), .zero_flag_q(zero_flag_q), .port_a_direction_reg(dir_a), .port_b_direction_reg(dir_b),
      .port_c_direction_reg(dir_c), .file_wr_q(file_wr_q), .bad_operand_q(bad_operand_q));
   // Compare one result, count it
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Xorshift keeps the run repeatable
   function automatic logic [31:0] nxt(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // One instruction a cycle; results of the previous one checked mid-cycle
   // Two passes, each opened by a reset; the second reset follows the 300th instruction of the first pass
   initial begin
      repeat (2) begin
      rst_n <= 1'b0;
      instr_valid <= 1'b0; // No stale instruction at release
      repeat (4) @(posedge mclk);
      acc = 0;
      z = 0;
      wr = 0;
      bad = 0;
      d = '{3{255}};
      rst_n <= 1'b1;
      repeat (300) begin
         @(posedge mclk);
         seed = nxt(seed);
         v = seed[31] | seed[30];
         t = seed[$bits(xad_instr_type)-1:0];
         fd = seed[29:22];
         instr_valid <= v;
         instr <= t;
         file_rdata <= fd;
         @(negedge mclk);
         chk(acc_q, acc);
         chk(zero_flag_q, z);
         chk({dir_a, dir_b}, {8'(d[0]), 8'(d[1])});
         chk(dir_c, d[2]);
         chk(file_wr_q.we ? 16'(file_wr_q) : 16'h0000, wr);
         chk(bad_operand_q, bad);
         wr = 0;
         bad = 0;
         // Operand 0..4 is refused and only flagged
         if (v) case (t.op)
            XAD_OP_LOAD_DIR: if (t.dir_sel > 4) d[t.dir_sel - 5] = acc; else bad = 1;
            XAD_OP_XOR_LIT: begin
               acc ^= t.literal;
               z = acc == 0;
            end
            XAD_OP_XOR_FILE: begin
               res = acc ^ fd;
               z = res == 0;
               if (t.dest) wr = {1'b1, t.file_addr, 8'(res)};
               else acc = res;
            end
            default: ;
         endcase
      end
      end
      tally_and_finish();
   end
endmodule
